//--- rtl/supervisor_watchdog.sv
// supply, pushbutton and watchdog reset supervisor
`include "supervisor_consts.svh"
`default_nettype none
module supervisor_watchdog #(
    parameter int CNT_W           = `CNT_WIDTH,
    parameter int RESET_CYCLES    = `RESET_MIN_CYC,
    parameter int WDT_LOW_CYCLES  = `WDT_LOW_CYC,
    parameter int WDT_OPEN_CYCLES = `WDT_OPEN_CYC,
    parameter int WDT_HIGH_CYCLES = `WDT_HIGH_CYC,
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire logic                  supply_low,
    input  wire logic                  tolerance_select,
    input  wire logic                  manual_reset_n,
    input  wire logic                  strobe_n,
    input  wire supervisor_pkg::tsel_t timeout_select,
    output var  logic                  trip_level_low,
    output var  logic                  reset_active,
    input  wire logic                  reset_n_in,
    output var  logic                  reset_n_out,
    output var  logic                  reset_n_drive_n,
    output var  logic                  reset_n_seen
);
    import supervisor_pkg::*;

    // ======================================================================
    // elaboration checks
    // ======================================================================
    if (CNT_W < 2 || CNT_W > 30) begin : g_bad_width
        $error("counter width out of range");
    end
    if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << CNT_W)) begin : g_bad_rst
        $error("reset interval does not fit the counter");
    end
    if (WDT_LOW_CYCLES < 1 || WDT_OPEN_CYCLES < 1 ||
        WDT_HIGH_CYCLES < 1) begin : g_bad_wdt_zero
        $error("watchdog period must be at least one cycle");
    end
    // a strobe spends several cycles in its pin stages before it counts
    if (WDT_LOW_CYCLES < 8 || WDT_OPEN_CYCLES < 8 ||
        WDT_HIGH_CYCLES < 8) begin : g_bad_wdt_short
        $error("watchdog period shorter than the strobe pin latency");
    end
    if (WDT_HIGH_CYCLES >= (1 << CNT_W) ||
        WDT_OPEN_CYCLES >= (1 << CNT_W) ||
        WDT_LOW_CYCLES >= (1 << CNT_W)) begin : g_bad_wdt_fit
        $error("watchdog period does not fit the counter");
    end
    if (DEBOUNCE_CYCLES < 1 ||
        DEBOUNCE_CYCLES >= (1 << CNT_W)) begin : g_bad_deb
        $error("debounce time does not fit the counter");
    end

    // ======================================================================
    // declarations
    // ======================================================================
    logic [5:0]       pins_raw;
    logic [5:0]       pins_s;
    logic             supply_low_s;
    logic             button_n_s;
    logic             strobe_n_s;
    logic             tol_s;
    tsel_t            tsel_s;
    logic             wire_level_s;

    logic             btn_stable_q;
    logic             btn_stable_d;
    logic [CNT_W-1:0] deb_cnt_q;
    logic [CNT_W-1:0] deb_cnt_d;

    logic             strobe_prev_q;
    logic             strobe_prev_d;
    logic             strobe_fall;

    state_t           state_q;
    state_t           state_d;
    logic [CNT_W-1:0] hold_cnt_q;
    logic [CNT_W-1:0] hold_cnt_d;
    logic [CNT_W-1:0] wd_cnt_q;
    logic [CNT_W-1:0] wd_cnt_d;
    logic             wd_expire;
    logic [CNT_W-1:0] wd_limit;
    logic             cause_level;

    logic             reset_q;
    logic             reset_d;
    logic             trip_low_q;
    logic             trip_low_d;
    logic             pin_seen_q;
    logic             pin_seen_d;

    // ======================================================================
    // helpers
    // ======================================================================
    // terminal count for the selected watchdog period
    function automatic logic [CNT_W-1:0] period_of(input tsel_t sel);
        logic [CNT_W-1:0] lim;
        lim = CNT_W'(WDT_OPEN_CYCLES);
        if (sel == `TSEL_LOW) begin
            lim = CNT_W'(WDT_LOW_CYCLES);
        end else if (sel == `TSEL_HIGH) begin
            lim = CNT_W'(WDT_HIGH_CYCLES);
        end
        return lim;
    endfunction

    // counter step, saturating at the top
    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
        return (&v) ? v : CNT_W'(v + 1'b1);
    endfunction

    // true on the last cycle of an n-cycle count
    function automatic logic reached(input logic [CNT_W-1:0] v,
                                     input logic [CNT_W-1:0] n);
        return v >= n - 1'b1;
    endfunction

    // ======================================================================
    // pin synchronisers
    // ======================================================================
    // all pins come from outside the clock domain
    assign pins_raw = {supply_low, manual_reset_n, strobe_n,
                       tolerance_select, timeout_select};

    pin_sync3 #(
        .WIDTH   (6),
        .RST_VAL (`SYNC_RST_VAL)
    ) u_sync (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .pin_in    (pins_raw),
        .level_out (pins_s)
    );

    assign supply_low_s = pins_s[5];
    assign button_n_s   = pins_s[4];
    assign strobe_n_s   = pins_s[3];
    assign tol_s        = pins_s[2];
    assign tsel_s       = pins_s[1:0];

    // the reset wire may be pulled low by other parts of the board
    pin_sync3 #(
        .WIDTH   (1),
        .RST_VAL (1'b0)
    ) u_wire_sync (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .pin_in    (reset_n_in),
        .level_out (wire_level_s)
    );

    // ======================================================================
    // pushbutton debounce
    // ======================================================================
    // level must hold a full debounce time before it is accepted
    always_comb begin
        btn_stable_d = btn_stable_q;
        deb_cnt_d    = '0;
        if (button_n_s != btn_stable_q) begin
            if (reached(deb_cnt_q, CNT_W'(DEBOUNCE_CYCLES))) begin
                btn_stable_d = button_n_s;
            end else begin
                deb_cnt_d = bump(deb_cnt_q);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            btn_stable_q <= 1'b1;
            deb_cnt_q    <= '0;
        end else if (clk_en) begin
            btn_stable_q <= btn_stable_d;
            deb_cnt_q    <= deb_cnt_d;
        end
    end

    // ======================================================================
    // strobe edge detect
    // ======================================================================
    // only a high-to-low change counts, steady levels do nothing
    assign strobe_prev_d = strobe_n_s;
    assign strobe_fall   = strobe_prev_q & ~strobe_n_s;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobe_prev_q <= 1'b1;
        end else if (clk_en) begin
            strobe_prev_q <= strobe_prev_d;
        end
    end

    // ======================================================================
    // reset causes and watchdog expiry
    // ======================================================================
    // held causes: supply fault, or button still pressed
    assign cause_level = supply_low_s | ~btn_stable_q;
    assign wd_limit    = period_of(tsel_s);
    assign wd_expire   = (state_q == st_run) && !strobe_fall &&
                         reached(wd_cnt_q, wd_limit);

    // ======================================================================
    // supervisor state machine
    // ======================================================================
    // hold counter restarts on every cause, watchdog runs only in st_run
    always_comb begin
        state_d    = state_q;
        hold_cnt_d = hold_cnt_q;
        wd_cnt_d   = '0;
        case (state_q)
            st_hold: begin
                if (cause_level) begin
                    hold_cnt_d = '0;
                end else if (reached(hold_cnt_q, CNT_W'(RESET_CYCLES))) begin
                    state_d    = st_run;
                    hold_cnt_d = '0;
                end else begin
                    hold_cnt_d = bump(hold_cnt_q);
                end
            end
            st_run: begin
                if (cause_level || wd_expire) begin
                    state_d    = st_hold;
                    hold_cnt_d = '0;
                end else if (strobe_fall) begin
                    wd_cnt_d = '0;
                end else begin
                    wd_cnt_d = bump(wd_cnt_q);
                end
            end
            default: begin
                state_d    = st_hold;
                hold_cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q    <= st_hold;
            hold_cnt_q <= '0;
            wd_cnt_q   <= '0;
        end else if (clk_en) begin
            state_q    <= state_d;
            hold_cnt_q <= hold_cnt_d;
            wd_cnt_q   <= wd_cnt_d;
        end
    end

    // ======================================================================
    // output registers
    // ======================================================================
    // reset follows the next state so both pins move together
    always_comb begin
        reset_d    = (state_d == st_hold);
        trip_low_d = tol_s;
        pin_seen_d = wire_level_s;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reset_q    <= 1'b1;
            trip_low_q <= 1'b0;
            pin_seen_q <= 1'b0;
        end else if (clk_en) begin
            reset_q    <= reset_d;
            trip_low_q <= trip_low_d;
            pin_seen_q <= pin_seen_d;
        end
    end

    // ======================================================================
    // pins
    // ======================================================================
    // open drain: pull low while reset, otherwise float
    assign reset_active    = reset_q;
    assign reset_n_out     = 1'b0;
    assign reset_n_drive_n = ~reset_q;
    assign reset_n_seen    = pin_seen_q;
    assign trip_level_low  = trip_low_q;
endmodule // supervisor_watchdog
`default_nettype wire

//--- rtl/supervisor_consts.svh
// timing, encoding and reset constants of the supply and watchdog supervisor
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH

// ==========================================================================
// clock rate
// ==========================================================================
`define CLK_KHZ          250000

// ==========================================================================
// times in milliseconds
// ==========================================================================
`define RESET_MIN_MS     250
`define WDT_LOW_MS       150
`define WDT_OPEN_MS      600
`define WDT_HIGH_MS      1200
`define WDT_HIGH_MIN_MS  400
`define WDT_HIGH_MAX_MS  2000
`define DEBOUNCE_MS      10

// ==========================================================================
// times in clock cycles (least times, exact at this clock rate)
// ==========================================================================
`define RESET_MIN_CYC    (`RESET_MIN_MS * `CLK_KHZ)
`define WDT_LOW_CYC      (`WDT_LOW_MS * `CLK_KHZ)
`define WDT_OPEN_CYC     (`WDT_OPEN_MS * `CLK_KHZ)
`define WDT_HIGH_CYC     (`WDT_HIGH_MS * `CLK_KHZ)
`define WDT_HIGH_MIN_CYC (`WDT_HIGH_MIN_MS * `CLK_KHZ)
`define WDT_HIGH_MAX_CYC (`WDT_HIGH_MAX_MS * `CLK_KHZ)
`define DEBOUNCE_CYC     (`DEBOUNCE_MS * `CLK_KHZ)

// ==========================================================================
// timeout select codes and synchroniser reset values
// ==========================================================================
`define TSEL_LOW         2'b00
`define TSEL_OPEN        2'b01
`define TSEL_HIGH        2'b11
`define SYNC_RST_VAL     6'h38
`define CNT_WIDTH        29

`endif

//--- rtl/supervisor_pkg.sv
// types shared by the supply and watchdog supervisor
`default_nettype none
package supervisor_pkg;
    // supervisor state: holding reset, or processor running
    typedef enum logic {
        st_hold,
        st_run
    } state_t;

    // decoded three-level timeout select
    typedef logic [1:0] tsel_t;
endpackage : supervisor_pkg
`default_nettype wire

//--- rtl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync3 #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] lvl_q;
    logic [WIDTH-1:0] lvl_d;

    // ======================================================================
    // filter: a bit changes only once stages two and three agree
    // ======================================================================
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            lvl_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : lvl_q[i];
        end
    end

    // stage flops, first stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q  <= RST_VAL;
            s2_q  <= RST_VAL;
            s3_q  <= RST_VAL;
            lvl_q <= RST_VAL;
        end else if (clk_en) begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule // pin_sync3
`default_nettype wire

//--- verification/supervisor_checker.sv
// concurrent assertion checker for the supervisor ports
`default_nettype none
module supervisor_checker #(
    parameter int RESET_CYCLES    = 20,
    parameter int WDT_LOW_CYCLES  = 30,
    parameter int WDT_OPEN_CYCLES = 60,
    parameter int WDT_HIGH_CYCLES = 120
) (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  clk_en,
    input wire logic                  supply_low,
    input wire logic                  tolerance_select,
    input wire logic                  manual_reset_n,
    input wire logic                  strobe_n,
    input wire supervisor_pkg::tsel_t timeout_select,
    input wire logic                  trip_level_low,
    input wire logic                  reset_active,
    input wire logic                  reset_n_out,
    input wire logic                  reset_n_drive_n
);
    timeunit 1ns;
    timeprecision 100ps;
    import supervisor_pkg::*;
    localparam int REL_LO = RESET_CYCLES + 2;
    localparam int REL_HI = RESET_CYCLES + 8;
    int   lim;
    int   idle_q, idle_d, quiet_q, quiet_d, hi_q, hi_d;
    logic strobe_prev_q;
    // ==================================================================
    // helper counters
    // ==================================================================
    // idle: run cycles without strobe change; quiet: no outside cause
    always_comb begin
        lim = (timeout_select == 2'b00) ? WDT_LOW_CYCLES :
              (timeout_select == 2'b11) ? WDT_HIGH_CYCLES : WDT_OPEN_CYCLES;
        idle_d = (reset_active || strobe_n != strobe_prev_q) ? 0 : idle_q + 1;
        quiet_d = (supply_low || !manual_reset_n) ? 0 : quiet_q + 1;
        if (quiet_q > 1000) begin
            quiet_d = quiet_q;
        end
        hi_d = reset_active ? hi_q + 1 : 0;
    end
    // register the helper counters
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idle_q        <= 0;
            quiet_q       <= 0;
            hi_q          <= 0;
            strobe_prev_q <= 1'b1;
        end else if (clk_en) begin
            idle_q        <= idle_d;
            quiet_q       <= quiet_d;
            hi_q          <= hi_d;
            strobe_prev_q <= strobe_n;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset || !clk_en);
    // ==================================================================
    // assertions
    // ==================================================================
    a_supply_trip: assert property (supply_low [*6] |=> reset_active)
        else $error("reset not asserted on supply fault");
    a_supply_release: assert property ($fell(supply_low) |->
        ##[REL_LO:REL_HI] !reset_active)
        else $error("reset not released in time after supply fault");
    a_hold_min: assert property ($fell(reset_active) |->
        hi_q >= RESET_CYCLES)
        else $error("reset interval shorter than minimum");
    a_button_press: assert property (!manual_reset_n [*8] ##1
        !manual_reset_n [*4] |=> reset_active)
        else $error("held button gave no reset");
    a_button_release: assert property ($rose(manual_reset_n) &&
        reset_active |-> reset_active [*8] ##1 reset_active [*8])
        else $error("button reset released too soon");
    a_wdt_expiry: assert property (idle_q <= lim + 8)
        else $error("watchdog did not expire");
    a_wdt_early: assert property ($rose(reset_active) &&
        quiet_q > 12 |-> idle_q + 8 >= lim)
        else $error("watchdog expired early");
    a_trip_follow: assert property ($stable(tolerance_select) [*8]
        |=> trip_level_low == tolerance_select)
        else $error("trip level does not follow tolerance select");
    a_drive_mirror: assert property (reset_n_drive_n == !reset_active)
        else $error("open-drain enable disagrees with reset");
    a_od_low: assert property (reset_n_out == 1'b0)
        else $error("open-drain data not low");
    c_wdt: cover property ($rose(reset_active) && quiet_q > 12);
    c_supply: cover property ($fell(supply_low));
    c_button: cover property ($rose(manual_reset_n) && reset_active);
endmodule // supervisor_checker
`default_nettype wire

//--- verification/host_model.sv
// host processor model that feeds the watchdog strobe
`default_nettype none
module host_model (
    input  wire logic       clk,
    input  wire logic       reset_active,
    input  wire logic [1:0] mode,
    input  var  int         period,
    output var  logic       strobe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    // mode 0 idle high, 1 three-cycle low pulses each period, 2 steady low
    always @(posedge clk) begin
        #1;
        if (reset_active || mode == 2'd0) begin
            cnt <= 0;
            strobe_n <= 1'b1;
        end else if (mode == 2'd2) begin
            strobe_n <= 1'b0;
        end else begin
            cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
            strobe_n <= !(cnt < 3);
        end
    end
endmodule // host_model
`default_nettype wire

//--- verification/testbench.sv
// self-checking testbench for the supply and watchdog supervisor
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import supervisor_pkg::*;
    localparam int RST_C = 20;
    localparam int DEB_C = 5;
    logic clk = 1'b0, reset = 1'b1, supply_low = 1'b0;
    logic tolerance_select = 1'b0, manual_reset_n = 1'b1, clk_en = 1'b1;
    logic strobe_n, trip_level_low, reset_active, reset_n_out;
    logic reset_n_drive_n, reset_n_seen;
    logic [1:0] mode = 2'd0;
    tsel_t timeout_select = 2'b01;
    int period = 10, err_total = 0, n_checks = 0;
    // pull-up on the open-drain reset wire
    wire reset_n_in = reset_n_drive_n ? 1'b1 : reset_n_out;
    always #2 clk = ~clk;
    supervisor_watchdog #(.RESET_CYCLES(RST_C), .WDT_LOW_CYCLES(30),
        .WDT_OPEN_CYCLES(60), .WDT_HIGH_CYCLES(120),
        .DEBOUNCE_CYCLES(DEB_C)) i_dut (
        .clk(clk), .reset(reset), .clk_en(clk_en), .supply_low(supply_low),
        .tolerance_select(tolerance_select), .manual_reset_n(manual_reset_n),
        .strobe_n(strobe_n), .timeout_select(timeout_select),
        .trip_level_low(trip_level_low), .reset_active(reset_active),
        .reset_n_in(reset_n_in), .reset_n_out(reset_n_out),
        .reset_n_drive_n(reset_n_drive_n), .reset_n_seen(reset_n_seen));
    host_model i_host (.clk(clk), .reset_active(reset_active),
        .mode(mode), .period(period), .strobe_n(strobe_n));
    // ==================================================================
    // helpers
    // ==================================================================
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic chk_range(input string what, input int lo, input int hi,
                             input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            err_total++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, g);
        end
    endtask
    // cycles until reset reaches the wanted level, bounded
    task automatic wait_rst(input logic want, output int k);
        k = 0;
        while (reset_active !== want && k < 400) begin
            cyc(1);
            k++;
        end
    endtask
    // count reset cycles over a quiet span
    task automatic count_rst(input int span, output int k);
        k = 0;
        repeat (span) begin
            cyc(1);
            k += int'(reset_active === 1'b1);
        end
    endtask
    function automatic int lim_of(input tsel_t t);
        return (t == 2'b00) ? 30 : (t == 2'b11) ? 120 : 60;
    endfunction
    task automatic supply_pulse();
        int k;
        supply_low = 1'b1;
        cyc(11 + $urandom_range(9));
        chk_bit("reset_active", 1'b1, reset_active);
        chk_bit("reset_n_drive_n", 1'b0, reset_n_drive_n);
        chk_bit("reset_n_seen", 1'b0, reset_n_seen);
        supply_low = 1'b0;
        wait_rst(1'b0, k);
        chk_range("supply release", RST_C + 2, RST_C + 8, k);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==================================================================
    // main sequence
    // ==================================================================
    initial begin
        int k;
        static tsel_t tab[4] = '{2'b00, 2'b01, 2'b11, 2'b10};
        void'($urandom(32'h8da956c1));
        cyc(20);
        reset = 1'b0;
        foreach (tab[i]) begin
            timeout_select = tab[i];
            tolerance_select = 1'($urandom);
            mode = 2'd0;
            supply_pulse();
            chk_bit("trip_level_low", tolerance_select, trip_level_low);
            wait_rst(1'b1, k);
            chk_range("wd period", lim_of(tab[i]) - 1, lim_of(tab[i]) + 3, k);
            wait_rst(1'b0, k);
            chk_range("expiry hold", RST_C, RST_C + 2, k);
            mode = 2'd1;
            period = 6 + $urandom_range(lim_of(tab[i]) - 14);
            count_rst(3 * lim_of(tab[i]), k);
            chk_range("strobed run", 0, 0, k);
            chk_bit("reset_n_seen", 1'b1, reset_n_seen);
            mode = 2'd2;
            wait_rst(1'b1, k);
            chk_range("steady low", 1, lim_of(tab[i]) + 8, k);
            wait_rst(1'b0, k);
            chk_range("steady hold", RST_C, RST_C + 2, k);
        end
        mode = 2'd1;
        manual_reset_n = 1'b0;
        cyc(3);
        manual_reset_n = 1'b1;
        count_rst(20, k);
        chk_range("button glitch", 0, 0, k);
        manual_reset_n = 1'b0;
        cyc(15 + $urandom_range(20));
        chk_bit("reset_active", 1'b1, reset_active);
        manual_reset_n = 1'b1;
        wait_rst(1'b0, k);
        chk_range("button release", RST_C + DEB_C + 2, RST_C + DEB_C + 8, k);
        manual_reset_n = 1'b0;
        cyc(15);
        manual_reset_n = 1'b1;
        cyc(15);
        supply_pulse();
        // frozen enable: the reset interval waits out the frozen span
        supply_low = 1'b1;
        cyc(12);
        supply_low = 1'b0;
        cyc(6);
        clk_en = 1'b0;
        count_rst(30, k);
        chk_range("frozen hold", 30, 30, k);
        clk_en = 1'b1;
        wait_rst(1'b0, k);
        chk_range("frozen release", RST_C - 3, RST_C - 1, k);
        finish_test();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("mismatch run length expected done seen timeout");
        finish_test();
    end
endmodule // testbench
bind supervisor_watchdog supervisor_checker #(
    .RESET_CYCLES(RESET_CYCLES), .WDT_LOW_CYCLES(WDT_LOW_CYCLES),
    .WDT_OPEN_CYCLES(WDT_OPEN_CYCLES), .WDT_HIGH_CYCLES(WDT_HIGH_CYCLES)
) i_chk (
    .clk(clk), .reset(reset), .clk_en(clk_en), .supply_low(supply_low),
    .tolerance_select(tolerance_select), .manual_reset_n(manual_reset_n),
    .strobe_n(strobe_n), .timeout_select(timeout_select),
    .trip_level_low(trip_level_low), .reset_active(reset_active),
    .reset_n_out(reset_n_out), .reset_n_drive_n(reset_n_drive_n));
`default_nettype wire
